// File: isk_defines.svh
// constants for the increment-skip / or decode block
`ifndef ISK_DEFINES_SVH
`define ISK_DEFINES_SVH
`define ISK_OP_INC_SKIP 6'h0f
`define ISK_OP_OR_FILE 6'h04
`define ISK_OP_OR_LIT 4'hd
`define ISK_D_BIT 5
`define ISK_ACC_RST 8'h00
`define ISK_FILE_DEPTH 32
`endif

// File: isk_pkg.sv
// types for the increment-skip / or decode block
package isk_pkg;
  typedef enum logic [1:0] {
    ISK_OP_NONE,
    ISK_OP_INC_SKIP,
    ISK_OP_OR_LIT,
    ISK_OP_OR_FILE
  } isk_op_t;
  typedef enum logic {
    ISK_RUN,
    ISK_SQUASH
  } isk_state_t;
endpackage : isk_pkg

// File: isk_decode.sv
// opcode decoder for the three supported instructions
`timescale 1ns/1ps
`include "isk_defines.svh"
module isk_decode (
  input wire logic [11:0] instr,
  output isk_pkg::isk_op_t op
);
  import isk_pkg::*;
  always_comb begin
    if (instr[11:6] == `ISK_OP_INC_SKIP) begin // see RULE1
      op = ISK_OP_INC_SKIP;
    end else if (instr[11:8] == `ISK_OP_OR_LIT) begin // see RULE4
      op = ISK_OP_OR_LIT;
    end else if (instr[11:6] == `ISK_OP_OR_FILE) begin // see RULE5
      op = ISK_OP_OR_FILE;
    end else begin
      op = ISK_OP_NONE;
    end
  end
endmodule : isk_decode

// File: isk_core.sv
// execute logic for increment-with-skip and the two or instructions
// ****************************************************************
// Functional notes
// RULE1 - increment-skip opcode adds one to addressed file, status untouched
// RULE2 - destination bit 0 writes accumulator, 1 writes file register
// RULE3 - zero result squashes fetched next instruction, executing a nop
// RULE4 - or-literal ors accumulator with literal, sets zero flag, one cycle
// RULE5 - or-file ors accumulator with file, routes by destination, sets zero
// RULE6 - zero flag set when eight-bit result is zero, else cleared
// ****************************************************************
`timescale 1ns/1ps
`include "isk_defines.svh"
module isk_core #(
  parameter int DEPTH = `ISK_FILE_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  input wire logic [7:0] file_rdata,
  output logic [4:0] file_addr,
  output logic [7:0] file_wdata,
  output logic file_we,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic flush,
  output logic busy
);
  import isk_pkg::*;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  isk_op_t op;
  isk_state_t state_r;
  logic [7:0] result;
  logic to_file;
  logic exec;
  logic [7:0] acc_r;
  logic zero_r;
  logic [4:0] addr_r;
  logic [7:0] wdata_r;
  logic we_r;

  isk_decode u_dec (
    .instr(instr),
    .op(op)
  );

  // ****************************************************************
  // datapath
  // ****************************************************************
  // a squashed slot executes nothing, even if the core presents a word;
  // nor does the slot after a file write, which holds the one file port
  assign exec = instr_valid && (state_r == ISK_RUN) && !we_r;
  assign to_file = instr[`ISK_D_BIT];

  always_comb begin
    case (op)
      ISK_OP_INC_SKIP: result = file_rdata + 8'h01; // see RULE1
      ISK_OP_OR_LIT: result = acc_r | instr[7:0]; // see RULE4
      ISK_OP_OR_FILE: result = acc_r | file_rdata; // see RULE5
      default: result = 8'h00;
    endcase
  end

  // the write lands a cycle late, so the port points at the held address meanwhile
  assign file_addr = we_r ? addr_r : instr[4:0]; // see RULE2

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_r <= `ISK_ACC_RST;
    end else if (exec && op == ISK_OP_OR_LIT) begin
      acc_r <= result; // see RULE4
    end else if (exec && op != ISK_OP_NONE && !to_file) begin
      acc_r <= result; // see RULE2
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      we_r <= 1'b0;
      addr_r <= 5'h00;
      wdata_r <= 8'h00;
    end else begin
      // writes past a smaller file are dropped rather than aliased
      we_r <= exec && to_file && (op == ISK_OP_INC_SKIP || op == ISK_OP_OR_FILE)
        && (int'(instr[4:0]) < DEPTH); // see RULE2
      addr_r <= instr[4:0];
      wdata_r <= result;
    end
  end

  // increment-skip leaves the flag alone; only the or forms touch it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      zero_r <= 1'b0;
    end else if (exec && (op == ISK_OP_OR_LIT || op == ISK_OP_OR_FILE)) begin
      zero_r <= is_zero(result); // see RULE6
    end
  end

  // ****************************************************************
  // skip sequencing
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ISK_RUN;
    end else begin
      case (state_r)
        ISK_RUN: begin
          if (exec && op == ISK_OP_INC_SKIP && is_zero(result)) begin
            state_r <= ISK_SQUASH; // see RULE3
          end
        end
        ISK_SQUASH: state_r <= ISK_RUN;
        default: state_r <= ISK_RUN;
      endcase
    end
  end

  // flush tells the core to drop the prefetched word while the nop slot runs
  assign flush = (state_r == ISK_SQUASH); // see RULE3
  // busy covers both slots in which no word can be taken
  assign busy = flush || we_r;
  assign acc = acc_r;
  assign zero_flag = zero_r;
  assign file_we = we_r;
  assign file_wdata = wdata_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_skip_hit;
    exec && op == ISK_OP_INC_SKIP && is_zero(result);
  endsequence

  AST_SKIP_FLUSH: assert property (@(posedge clock) disable iff (sys_rst) // see RULE3
    s_skip_hit |=> flush ##1 !flush)
    else $error("zero increment did not squash exactly one slot");
  AST_NO_SKIP: assert property (@(posedge clock) disable iff (sys_rst) // see RULE3
    exec && op == ISK_OP_INC_SKIP && !is_zero(result) |=> !flush)
    else $error("nonzero increment squashed a slot");
  AST_INC_FLAG: assert property (@(posedge clock) disable iff (sys_rst) // see RULE1
    exec && op == ISK_OP_INC_SKIP |=> $stable(zero_flag))
    else $error("increment changed the zero flag");
  AST_INC_VALUE: assert property (@(posedge clock) disable iff (sys_rst) // see RULE1
    exec && op == ISK_OP_INC_SKIP && to_file |=> file_we && file_wdata == $past(file_rdata) + 8'h01)
    else $error("increment wrote wrong value");
  AST_DEST_ACC: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    exec && op == ISK_OP_OR_FILE && !to_file |=> !file_we && acc == ($past(acc) | $past(file_rdata)))
    else $error("destination zero did not go to accumulator");
  AST_DEST_FILE: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    exec && op == ISK_OP_OR_FILE && to_file |=> file_we && $stable(acc))
    else $error("destination one did not go to file");
  AST_OR_LIT: assert property (@(posedge clock) disable iff (sys_rst) // see RULE4
    exec && op == ISK_OP_OR_LIT |=> acc == ($past(acc) | $past(instr[7:0])) && !flush)
    else $error("or literal result wrong");
  AST_OR_FILE_ZERO: assert property (@(posedge clock) disable iff (sys_rst) // see RULE5
    exec && op == ISK_OP_OR_FILE |=> zero_flag == (($past(acc) | $past(file_rdata)) == 8'h00))
    else $error("or file zero flag wrong");
  AST_ZERO_FLAG: assert property (@(posedge clock) disable iff (sys_rst) // see RULE6
    exec && op == ISK_OP_OR_LIT |=> zero_flag == (acc == 8'h00))
    else $error("zero flag does not match result");

  // ****************************************************************
  // write port and refusal checks
  // ****************************************************************
  sequence s_file_write;
    exec && to_file && (op == ISK_OP_INC_SKIP || op == ISK_OP_OR_FILE);
  endsequence

  sequence s_or_exec;
    exec && (op == ISK_OP_OR_LIT || op == ISK_OP_OR_FILE);
  endsequence

  // the nop slot takes no word and lasts one cycle only
  sequence s_squash_slot;
    flush && !exec ##1 !flush;
  endsequence

  AST_SKIP_SLOT: assert property (@(posedge clock) disable iff (sys_rst) // see RULE3
    s_skip_hit |=> s_squash_slot)
    else $error("squash slot took a word or lasted too long");
  AST_FLUSH_CAUSE: assert property (@(posedge clock) disable iff (sys_rst) // see RULE3
    !(exec && op == ISK_OP_INC_SKIP && is_zero(result)) |=> !flush)
    else $error("flush raised without a zero increment");
  AST_INC_ACC: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    exec && op == ISK_OP_INC_SKIP && !to_file |=>
      !file_we && acc == $past(file_rdata) + 8'h01)
    else $error("increment to accumulator wrong");
  AST_WRITE_ADDR: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    s_file_write |=> file_we && file_addr == $past(instr[4:0]))
    else $error("file write aimed at the wrong register");
  AST_WRITE_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    file_we |-> !exec && busy)
    else $error("word taken while the file port was writing");
  // idle and refused slots must leave acc and zero_flag where they stood, with no file write and no flush
  AST_NONE_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    exec && op == ISK_OP_NONE |=>
      $stable(acc) && $stable(zero_flag) && !file_we && !flush)
    else $error("unsupported opcode changed state");
  AST_IDLE_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // see RULE2
    !exec |=> $stable(acc) && $stable(zero_flag) && !file_we && !flush)
    else $error("state changed with no word taken");
  AST_OR_ONE_CYCLE: assert property (@(posedge clock) disable iff (sys_rst) // see RULE5
    s_or_exec |=> !flush)
    else $error("or instruction took a second cycle");
  AST_OR_FILE_DATA: assert property (@(posedge clock) disable iff (sys_rst) // see RULE5
    exec && op == ISK_OP_OR_FILE && to_file |=>
      file_wdata == ($past(acc) | $past(file_rdata)))
    else $error("or file wrote wrong value");
  AST_OR_LIT_DEST: assert property (@(posedge clock) disable iff (sys_rst) // see RULE4
    exec && op == ISK_OP_OR_LIT |=> !file_we)
    else $error("or literal wrote the file");
  AST_OR_LIT_CLEAR: assert property (@(posedge clock) disable iff (sys_rst) // see RULE6
    exec && op == ISK_OP_OR_LIT && instr[7:0] != 8'h00 |=> !zero_flag)
    else $error("nonzero literal left the zero flag set");
  // reset is not a disable here: it is the behaviour under test
  AST_RESET_STATE: assert property (@(posedge clock) // see RULE6
    sys_rst |=> acc == `ISK_ACC_RST && !zero_flag && !file_we && !flush)
    else $error("reset did not clear the execute state");
endmodule : isk_core

// File: isk_testbench.sv
// self-checking testbench for the increment-skip / or decode block
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [4:0] file_addr;
  logic [7:0] file_wdata;
  logic file_we;
  logic [7:0] acc;
  logic zero_flag;
  logic flush;
  logic busy;
  int err_count = 0;
  int tests_run = 0;
  always #12.5 clock = ~clock;
  isk_core u_dut (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata),
    .file_we(file_we), .acc(acc), .zero_flag(zero_flag), .flush(flush), .busy(busy));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // hold keeps valid up so the next word sits in the slot that follows
  task op(input logic [11:0] w, input logic [7:0] rd, input logic hold, input logic ca);
    instr_valid = 1'b1;
    instr = w;
    file_rdata = rd;
    #1;
    if (ca) chk("addr", {3'h0, w[4:0]}, {3'h0, file_addr});
    @(posedge clock);
    #1;
    if (!hold) instr_valid = 1'b0;
  endtask : op
  task gap;
    @(posedge clock);
    #1;
  endtask : gap
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    chk("acc", 8'h00, acc);
    chk("zero", 8'h00, {7'h00, zero_flag});
    chk("we", 8'h00, {7'h00, file_we});
    chk("wdata", 8'h00, file_wdata);
    chk("flush", 8'h00, {7'h00, flush});
    chk("busy", 8'h00, {7'h00, busy});
    $display("test reset done");
  endtask : t_reset
  task t_zero;
    op(12'hd00, 8'h00, 1'b0, 1'b0);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h01, {7'h00, zero_flag});
    chk("we", 8'h00, {7'h00, file_we});
    gap();
    $display("test zero done");
  endtask : t_zero
  task t_inc;
    op(12'h3c7, 8'h41, 1'b0, 1'b1);
    chk("acc", 8'h42, acc);
    chk("we", 8'h00, {7'h00, file_we});
    chk("flush", 8'h00, {7'h00, flush});
    chk("zero", 8'h01, {7'h00, zero_flag});
    gap();
    op(12'h3e3, 8'hff, 1'b1, 1'b1);
    chk("we", 8'h01, {7'h00, file_we});
    chk("wdata", 8'h00, file_wdata);
    chk("waddr", 8'h03, {3'h0, file_addr});
    chk("flush", 8'h01, {7'h00, flush});
    chk("busy", 8'h01, {7'h00, busy});
    chk("zero", 8'h01, {7'h00, zero_flag});
    chk("acc", 8'h42, acc);
    op(12'hd01, 8'h00, 1'b0, 1'b0);
    chk("acc", 8'h42, acc);
    chk("we", 8'h00, {7'h00, file_we});
    chk("flush", 8'h00, {7'h00, flush});
    chk("busy", 8'h00, {7'h00, busy});
    gap();
    op(12'h3e3, 8'h10, 1'b0, 1'b1);
    chk("we", 8'h01, {7'h00, file_we});
    chk("wdata", 8'h11, file_wdata);
    chk("flush", 8'h00, {7'h00, flush});
    chk("acc", 8'h42, acc);
    gap();
    $display("test increment done");
  endtask : t_inc
  task t_or;
    op(12'hd9a, 8'h00, 1'b0, 1'b0);
    chk("acc", 8'hda, acc);
    chk("zero", 8'h00, {7'h00, zero_flag});
    chk("flush", 8'h00, {7'h00, flush});
    gap();
    op(12'h105, 8'h25, 1'b0, 1'b1);
    chk("acc", 8'hff, acc);
    chk("we", 8'h00, {7'h00, file_we});
    gap();
    op(12'h125, 8'h00, 1'b1, 1'b1);
    chk("we", 8'h01, {7'h00, file_we});
    chk("wdata", 8'hff, file_wdata);
    chk("waddr", 8'h05, {3'h0, file_addr});
    chk("busy", 8'h01, {7'h00, busy});
    chk("flush", 8'h00, {7'h00, flush});
    op(12'h3c7, 8'h01, 1'b0, 1'b0);
    chk("acc", 8'hff, acc);
    chk("we", 8'h00, {7'h00, file_we});
    gap();
    op(12'h3c7, 8'hff, 1'b1, 1'b1);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h00, {7'h00, zero_flag});
    chk("flush", 8'h01, {7'h00, flush});
    chk("we", 8'h00, {7'h00, file_we});
    op(12'hd35, 8'h00, 1'b0, 1'b0);
    chk("acc", 8'h00, acc);
    gap();
    op(12'hd9a, 8'h00, 1'b0, 1'b0);
    gap();
    op(12'hd35, 8'h00, 1'b0, 1'b0);
    chk("acc", 8'hbf, acc);
    chk("zero", 8'h00, {7'h00, zero_flag});
    gap();
    op(12'h2a5, 8'h07, 1'b0, 1'b0);
    chk("acc", 8'hbf, acc);
    chk("we", 8'h00, {7'h00, file_we});
    gap();
    $display("test or done");
  endtask : t_or
  task t_rerun;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_reset();
    op(12'h100, 8'h00, 1'b0, 1'b1);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h01, {7'h00, zero_flag});
    gap();
    op(12'h13f, 8'h80, 1'b0, 1'b1);
    chk("we", 8'h01, {7'h00, file_we});
    chk("wdata", 8'h80, file_wdata);
    chk("waddr", 8'h1f, {3'h0, file_addr});
    chk("zero", 8'h00, {7'h00, zero_flag});
    chk("acc", 8'h00, acc);
    gap();
    $display("test reset rerun done");
  endtask : t_rerun
  initial begin
    repeat (6) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_zero();
    t_inc();
    t_or();
    t_rerun();
    stop_test();
  end
  // the tests need well under 100 cycles; 400 leaves margin
  initial begin
    #(25 * 400);
    err_count++;
    stop_test();
  end
endmodule : testbench
